// ### rtl/dgpc_defs.vh
// dgpc_defs.vh: register map, field positions, reset values and counts
// for the converter gain, power and self-calibration control block.
// assumes: included by bare name from every design file of the block.
`ifndef DGPC_DEFS_VH
`define DGPC_DEFS_VH

// ============================================================
// register offsets
`define DGPC_ADDR_W 10
`define DGPC_A_PWR 10'h011
`define DGPC_A_CH0_GU 10'h040
`define DGPC_A_CH0_GL 10'h041
`define DGPC_A_CH1_GU 10'h044
`define DGPC_A_CH1_GL 10'h045
`define DGPC_A_CAL_CLK 10'h0e7
`define DGPC_A_CAL_SEL 10'h0e8
`define DGPC_A_CAL_CTL 10'h0e9
`define DGPC_A_CAL_INIT 10'h0ed

// ============================================================
// reset values
`define DGPC_RST_PWR 8'h00
`define DGPC_RST_GAIN 10'h000
`define DGPC_RST_CAL_CLK 8'h00
`define DGPC_RST_CAL_SEL 8'h00
`define DGPC_RST_CAL_CTL 2'h0
`define DGPC_RST_CAL_INIT 8'h00

// ============================================================
// power control fields
`define DGPC_PWR_REF 7
`define DGPC_PWR_CH0 6
`define DGPC_PWR_CH1 4
`define DGPC_PWR_BIAS 2

// ============================================================
// calibration fields
`define DGPC_CLK_EN 3
`define DGPC_CLK_DIV_HI 2
`define DGPC_CLK_DIV_LO 0
`define DGPC_CLK_SPD_HI 5
`define DGPC_CLK_SPD_LO 4
`define DGPC_SEL_CH0 0
`define DGPC_SEL_RSV1 1
`define DGPC_SEL_CH1 2
`define DGPC_SEL_RSV3 3
`define DGPC_CTL_EN 0
`define DGPC_CTL_START 1
`define DGPC_ST_DONE 7
`define DGPC_ST_BUSY 3
`define DGPC_ERR_ABORT 0
`define DGPC_ERR_STUCK 1
`define DGPC_ERR_SEL 2

// ============================================================
// gain and sample mapping; coefficient width and first SAR bit
`define DGPC_GAIN_W 10
`define DGPC_GAIN_MID 10'h200
`define DGPC_NARROW_W 11
`define DGPC_COEF_W 8
`define DGPC_SAR_MSB 3'h7

`endif

// ### rtl/dgpc_sample_map.v
// dgpc_sample_map.v: maps one channel's sample code and gain code to a
// registered output level; forced to zero while the channel is powered down.
// assumes: samples and controls synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
`include "dgpc_defs.vh"

module dgpc_sample_map #(
  parameter N = 16
) (
  input wire i_clk,                          // register clock
  input wire i_reset,                        // async reset, high
  input wire [N-1:0] i_sample,               // sample code
  input wire i_twos,                         // 1: twos complement samples
  input wire i_narrow,                       // 1: 11-bit samples in low bits
  input wire [`DGPC_GAIN_W-1:0] i_gain,      // signed full-scale gain code
  input wire i_pd,                           // channel powered down
  output reg [N+`DGPC_GAIN_W-1:0] o_level    // output level
);

  // ============================================================
  // code conversion
  // full scale: gain zero gives midscale, signed code offset by half range
  function [`DGPC_GAIN_W-1:0] fs_of;
    input [`DGPC_GAIN_W-1:0] g;
    begin
      fs_of = g + `DGPC_GAIN_MID;
    end
  endfunction

  wire [N-1:0] wide_code;
  wire [N-1:0] bin_code;
  wire [N-1:0] narrow_top;
  wire [`DGPC_NARROW_W-1:0] narrow_bin;
  wire [N+`DGPC_GAIN_W-1:0] nxt_level;

  // narrow codes made unsigned first, so replicated low bits follow the flipped sign
  assign narrow_bin = {i_sample[`DGPC_NARROW_W-1] ^ i_twos, i_sample[`DGPC_NARROW_W-2:0]};
  // narrow codes left-justified with top bits replicated so all ones maps to all ones
  assign narrow_top = {narrow_bin, narrow_bin[`DGPC_NARROW_W-1 -: (N-`DGPC_NARROW_W)]};
  assign wide_code = i_narrow ? narrow_top : i_sample;
  // twos complement: flipping the sign bit adds half the range
  assign bin_code = (i_twos & ~i_narrow) ? {~wide_code[N-1], wide_code[N-2:0]} : wide_code;
  // level proportional to code and to full scale
  assign nxt_level = bin_code * fs_of(i_gain);

  // output register
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_level <= {(N+`DGPC_GAIN_W){1'b0}};
    end else if (i_pd) begin
      o_level <= {(N+`DGPC_GAIN_W){1'b0}};
    end else begin
      o_level <= nxt_level;
    end
  end

endmodule // dgpc_sample_map
`default_nettype wire

// ### rtl/dgpc_cal_engine.v
// dgpc_cal_engine.v: one channel's self-calibration: successive
// approximation of an 8-bit trim coefficient from a comparator.
// assumes: i_tick is a one-cycle enable from the calibration divider.
`timescale 1ns/10ps
`default_nettype none
`include "dgpc_defs.vh"

module dgpc_cal_engine (
  input wire i_clk,                        // register clock
  input wire i_reset,                      // async reset, high
  input wire i_tick,                       // calibration clock enable
  input wire i_start,                      // start pulse for this channel
  input wire i_abort,                      // calibration clock stopped
  input wire i_bad_sel,                    // reserved select bits set
  input wire i_cmp,                        // comparator result
  input wire [`DGPC_COEF_W-1:0] i_init,    // initial coefficient
  output reg o_busy,                       // run in progress
  output reg o_done,                       // last run completed
  output reg [2:0] o_err,                  // error flags of last run
  output reg [`DGPC_COEF_W-1:0] o_coef     // coefficient in use
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SETTLE = 2'h1;
  localparam ST_SAR = 2'h2;

  reg [1:0] state_ff;
  reg [`DGPC_COEF_W-1:0] trial_ff;
  reg [2:0] bit_ff;
  reg seen_hi_ff;
  reg seen_lo_ff;

  // ============================================================
  // sequencer
  // the working trial never touches o_coef until the run completes
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= ST_IDLE;
      trial_ff <= {`DGPC_COEF_W{1'b0}};
      bit_ff <= 3'h0;
      seen_hi_ff <= 1'b0;
      seen_lo_ff <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_err <= 3'h0;
      o_coef <= {`DGPC_COEF_W{1'b0}};
    end else if (i_start) begin
      // a new start clears the old status of this channel
      state_ff <= ST_SETTLE;
      trial_ff <= i_init;
      bit_ff <= `DGPC_SAR_MSB;
      seen_hi_ff <= 1'b0;
      seen_lo_ff <= 1'b0;
      o_busy <= 1'b1;
      o_done <= 1'b0;
      o_err <= {i_bad_sel, 2'h0};
    end else begin
      case (state_ff)
        ST_IDLE: begin
          o_busy <= 1'b0;
        end
        ST_SETTLE: begin
          if (i_abort) begin
            state_ff <= ST_IDLE;
            o_busy <= 1'b0;
            o_err[`DGPC_ERR_ABORT] <= 1'b1;
          end else if (i_tick) begin
            // first trial: only the top bit set
            trial_ff <= {1'b1, {(`DGPC_COEF_W-1){1'b0}}};
            state_ff <= ST_SAR;
          end
        end
        ST_SAR: begin
          if (i_abort) begin
            state_ff <= ST_IDLE;
            o_busy <= 1'b0;
            o_err[`DGPC_ERR_ABORT] <= 1'b1;
          end else if (i_tick) begin
            seen_hi_ff <= seen_hi_ff | i_cmp;
            seen_lo_ff <= seen_lo_ff | ~i_cmp;
            if (bit_ff == 3'h0) begin
              // one pass gives the final coefficient, kept until a later run completes
              o_coef <= i_cmp ? trial_ff : (trial_ff & ~8'h01);
              o_done <= 1'b1;
              o_err[`DGPC_ERR_STUCK] <= ~((seen_hi_ff | i_cmp) & (seen_lo_ff | ~i_cmp));
              o_busy <= 1'b0;
              state_ff <= ST_IDLE;
            end else begin
              // keep or drop current bit, try the next lower one
              trial_ff <= (i_cmp ? trial_ff : (trial_ff & ~(8'h01 << bit_ff))) | (8'h01 << (bit_ff - 3'h1));
              bit_ff <= bit_ff - 3'h1;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // dgpc_cal_engine
`default_nettype wire

// ### rtl/dgpc_top.v
// dgpc_top.v: gain, power-down and self-calibration control of a
// dual-channel converter output stage, with its register port.
// assumes: register port and samples synchronous to I_CLK; a serial
// front end outside turns host transfers into single-cycle strobes.
//
// Operation
// - each channel holds a signed 10-bit gain code setting output amplitude.
// - channel gain split into 2 upper and 8 lower bits at paired registers.
// - gain zero gives midscale full scale; positive raises, negative lowers.
// - unsigned samples: all ones gives maximum, output proportional to code.
// - twos complement samples are offset by half range before scaling.
// - power register bit 6 powers down channel 0, bit 4 channel 1.
// - reading control register returns status of the selected channel.
// - done bit 7 set, bits 6 to 4 zero on success; nonzero is error.
// - one completed pass yields the final coefficients.
`timescale 1ns/10ps
`default_nettype none
`include "dgpc_defs.vh"

module dgpc_top #(
  parameter N = 16
) (
  input wire I_CLK,                                // 10 MHz register clock
  input wire I_RESET,                              // async reset, high
  input wire [`DGPC_ADDR_W-1:0] I_REG_ADDR,        // register address
  input wire [7:0] I_REG_WDATA,                    // write data
  input wire I_REG_WR,                             // write strobe
  input wire I_REG_RD,                             // read strobe
  output reg [7:0] O_REG_RDATA,                    // read data
  output reg O_REG_RVALID,                         // read data valid
  input wire [N-1:0] I_CH0_SAMPLE,                 // channel 0 sample code
  input wire [N-1:0] I_CH1_SAMPLE,                 // channel 1 sample code
  input wire I_TWOS_FMT,                           // 1: twos complement
  input wire I_NARROW,                             // 1: 11-bit samples
  input wire I_CH0_CMP,                            // channel 0 cal comparator
  input wire I_CH1_CMP,                            // channel 1 cal comparator
  output wire [N+`DGPC_GAIN_W-1:0] O_CH0_LEVEL,    // channel 0 output level
  output wire [N+`DGPC_GAIN_W-1:0] O_CH1_LEVEL,    // channel 1 output level
  output reg O_CH0_PD,                             // channel 0 powered down
  output reg O_CH1_PD,                             // channel 1 powered down
  output reg O_REF_PD,                             // reference disabled
  output reg O_BIAS_PD,                            // master bias disabled
  output reg [1:0] O_CAL_CLK_SPEED,                // comparator speed field
  output wire [`DGPC_COEF_W-1:0] O_CH0_CAL_COEF,   // channel 0 coefficient
  output wire [`DGPC_COEF_W-1:0] O_CH1_CAL_COEF,   // channel 1 coefficient
  output reg O_CAL_BUSY                            // calibration running
);

  // ============================================================
  // register storage
  reg [7:0] pwr_ff;
  reg [`DGPC_GAIN_W-1:0] ch0_gain_code_ff;
  reg [`DGPC_GAIN_W-1:0] ch1_gain_code_ff;
  reg [7:0] cal_clk_ff;
  reg [7:0] cal_sel_ff;
  reg [1:0] cal_ctl_ff;
  reg [7:0] cal_init_ff;
  reg [2:0] div_cnt_ff;
  reg tick_ff;
  reg [7:0] nxt_rdata;

  wire wr_pwr;
  wire wr_ctl;
  wire cal_start;
  wire clk_on;
  wire bad_sel;
  wire [2:0] div_max;
  wire ch0_busy;
  wire ch1_busy;
  wire ch0_done;
  wire ch1_done;
  wire [2:0] ch0_err;
  wire [2:0] ch1_err;

  // address match used by every register write
  function hit;
    input [`DGPC_ADDR_W-1:0] a;
    input [`DGPC_ADDR_W-1:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  // status byte: done, errors, busy, control bits
  function [7:0] status_byte;
    input done;
    input [2:0] err;
    input busy;
    input [1:0] ctl;
    begin
      status_byte = {done, err, busy, 1'b0, ctl};
    end
  endfunction

  assign wr_pwr = I_REG_WR & hit(I_REG_ADDR, `DGPC_A_PWR);
  assign wr_ctl = I_REG_WR & hit(I_REG_ADDR, `DGPC_A_CAL_CTL);
  // start when enable and start are written together
  assign cal_start = wr_ctl & I_REG_WDATA[`DGPC_CTL_EN] & I_REG_WDATA[`DGPC_CTL_START];
  assign clk_on = cal_clk_ff[`DGPC_CLK_EN];
  assign bad_sel = cal_sel_ff[`DGPC_SEL_RSV1] | cal_sel_ff[`DGPC_SEL_RSV3];
  assign div_max = cal_clk_ff[`DGPC_CLK_DIV_HI:`DGPC_CLK_DIV_LO];

  // ============================================================
  // register writes
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pwr_ff <= `DGPC_RST_PWR;
      ch0_gain_code_ff <= `DGPC_RST_GAIN;
      ch1_gain_code_ff <= `DGPC_RST_GAIN;
      cal_clk_ff <= `DGPC_RST_CAL_CLK;
      cal_sel_ff <= `DGPC_RST_CAL_SEL;
      cal_ctl_ff <= `DGPC_RST_CAL_CTL;
      cal_init_ff <= `DGPC_RST_CAL_INIT;
    end else if (I_REG_WR) begin
      if (wr_pwr) begin
        pwr_ff <= I_REG_WDATA;
      end
      // gain code upper and lower parts
      if (hit(I_REG_ADDR, `DGPC_A_CH0_GU)) begin
        ch0_gain_code_ff[9:8] <= I_REG_WDATA[1:0];
      end
      if (hit(I_REG_ADDR, `DGPC_A_CH0_GL)) begin
        ch0_gain_code_ff[7:0] <= I_REG_WDATA;
      end
      if (hit(I_REG_ADDR, `DGPC_A_CH1_GU)) begin
        ch1_gain_code_ff[9:8] <= I_REG_WDATA[1:0];
      end
      if (hit(I_REG_ADDR, `DGPC_A_CH1_GL)) begin
        ch1_gain_code_ff[7:0] <= I_REG_WDATA;
      end
      if (hit(I_REG_ADDR, `DGPC_A_CAL_CLK)) begin
        cal_clk_ff <= I_REG_WDATA;
      end
      if (hit(I_REG_ADDR, `DGPC_A_CAL_SEL)) begin
        cal_sel_ff <= I_REG_WDATA;
      end
      if (wr_ctl) begin
        cal_ctl_ff <= I_REG_WDATA[1:0];
      end
      if (hit(I_REG_ADDR, `DGPC_A_CAL_INIT)) begin
        cal_init_ff <= I_REG_WDATA;
      end
    end
  end

  // ============================================================
  // power and configuration outputs
  // host keeps reference and bias bits low; they are passed out as set
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CH0_PD <= 1'b0;
      O_CH1_PD <= 1'b0;
      O_REF_PD <= 1'b0;
      O_BIAS_PD <= 1'b0;
      O_CAL_CLK_SPEED <= 2'h0;
      O_CAL_BUSY <= 1'b0;
    end else begin
      O_CH0_PD <= pwr_ff[`DGPC_PWR_CH0];
      O_CH1_PD <= pwr_ff[`DGPC_PWR_CH1];
      O_REF_PD <= pwr_ff[`DGPC_PWR_REF];
      O_BIAS_PD <= pwr_ff[`DGPC_PWR_BIAS];
      O_CAL_CLK_SPEED <= cal_clk_ff[`DGPC_CLK_SPD_HI:`DGPC_CLK_SPD_LO];
      O_CAL_BUSY <= ch0_busy | ch1_busy;
    end
  end

  // ============================================================
  // calibration clock divider: tick every div_max+1 cycles while enabled
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      div_cnt_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else if (!clk_on) begin
      div_cnt_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else if (div_cnt_ff == div_max) begin
      div_cnt_ff <= 3'h0;
      tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 3'h1;
      tick_ff <= 1'b0;
    end
  end

  // ============================================================
  // calibration engines, one per channel
  dgpc_cal_engine u_cal0 (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_tick(tick_ff),
    .i_start(cal_start & cal_sel_ff[`DGPC_SEL_CH0]),
    .i_abort(~clk_on),
    .i_bad_sel(bad_sel),
    .i_cmp(I_CH0_CMP),
    .i_init(cal_init_ff),
    .o_busy(ch0_busy),
    .o_done(ch0_done),
    .o_err(ch0_err),
    .o_coef(O_CH0_CAL_COEF)
  );

  dgpc_cal_engine u_cal1 (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_tick(tick_ff),
    .i_start(cal_start & cal_sel_ff[`DGPC_SEL_CH1]),
    .i_abort(~clk_on),
    .i_bad_sel(bad_sel),
    .i_cmp(I_CH1_CMP),
    .i_init(cal_init_ff),
    .o_busy(ch1_busy),
    .o_done(ch1_done),
    .o_err(ch1_err),
    .o_coef(O_CH1_CAL_COEF)
  );

  // ============================================================
  // sample to level mapping
  dgpc_sample_map #(.N(N)) u_map0 (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_sample(I_CH0_SAMPLE),
    .i_twos(I_TWOS_FMT),
    .i_narrow(I_NARROW),
    .i_gain(ch0_gain_code_ff),
    .i_pd(O_CH0_PD),
    .o_level(O_CH0_LEVEL)
  );

  dgpc_sample_map #(.N(N)) u_map1 (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_sample(I_CH1_SAMPLE),
    .i_twos(I_TWOS_FMT),
    .i_narrow(I_NARROW),
    .i_gain(ch1_gain_code_ff),
    .i_pd(O_CH1_PD),
    .o_level(O_CH1_LEVEL)
  );

  // ============================================================
  // read mux; unmapped addresses read zero, unused upper bits zero
  always @* begin
    nxt_rdata = 8'h00;
    case (I_REG_ADDR)
      `DGPC_A_PWR: begin
        nxt_rdata = pwr_ff;
      end
      `DGPC_A_CH0_GU: begin
        nxt_rdata = {6'h00, ch0_gain_code_ff[9:8]};
      end
      `DGPC_A_CH0_GL: begin
        nxt_rdata = ch0_gain_code_ff[7:0];
      end
      `DGPC_A_CH1_GU: begin
        nxt_rdata = {6'h00, ch1_gain_code_ff[9:8]};
      end
      `DGPC_A_CH1_GL: begin
        nxt_rdata = ch1_gain_code_ff[7:0];
      end
      `DGPC_A_CAL_CLK: begin
        nxt_rdata = cal_clk_ff;
      end
      `DGPC_A_CAL_SEL: begin
        nxt_rdata = cal_sel_ff;
      end
      `DGPC_A_CAL_CTL: begin
        // status of the selected channel, channel 0 first
        if (cal_sel_ff[`DGPC_SEL_CH0]) begin
          nxt_rdata = status_byte(ch0_done, ch0_err, ch0_busy, cal_ctl_ff);
        end else if (cal_sel_ff[`DGPC_SEL_CH1]) begin
          nxt_rdata = status_byte(ch1_done, ch1_err, ch1_busy, cal_ctl_ff);
        end else begin
          nxt_rdata = {6'h00, cal_ctl_ff};
        end
      end
      `DGPC_A_CAL_INIT: begin
        nxt_rdata = cal_init_ff;
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // registered read answer, one cycle after the strobe
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_REG_RDATA <= 8'h00;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD) begin
        O_REG_RDATA <= nxt_rdata;
      end
    end
  end

endmodule // dgpc_top
`default_nettype wire

// ### testbench/dgpc_top_monitor.sv
// dgpc_top_monitor.sv: concurrent checks on the ports of dgpc_top.
// assumes: bound to every dgpc_top instance; one clock, async reset.
`timescale 1ns/10ps
`default_nettype none
`include "dgpc_defs.vh"

module dgpc_top_monitor #(
  parameter N = 16
) (
  input wire logic I_CLK, // register clock
  input wire logic I_RESET, // async reset, high
  input wire logic [`DGPC_ADDR_W-1:0] I_REG_ADDR, // register address
  input wire logic [7:0] I_REG_WDATA, // write data
  input wire logic I_REG_WR, // write strobe
  input wire logic I_REG_RD, // read strobe
  input wire logic [7:0] O_REG_RDATA, // read data
  input wire logic O_REG_RVALID, // read valid
  input wire logic [N-1:0] I_CH0_SAMPLE, // channel 0 sample
  input wire logic I_TWOS_FMT, // sample format
  input wire logic I_NARROW, // 11-bit samples
  input wire logic [N+`DGPC_GAIN_W-1:0] O_CH0_LEVEL, // channel 0 level
  input wire logic O_CH0_PD, // channel 0 down
  input wire logic O_CH1_PD, // channel 1 down
  input wire logic O_REF_PD, // reference down
  input wire logic O_BIAS_PD, // bias down
  input wire logic [1:0] O_CAL_CLK_SPEED, // comparator speed
  input wire logic [`DGPC_COEF_W-1:0] O_CH0_CAL_COEF, // channel 0 coefficient
  input wire logic [`DGPC_COEF_W-1:0] O_CH1_CAL_COEF, // channel 1 coefficient
  input wire logic O_CAL_BUSY // calibration running
);
  // ============================================================
  // common clocking and reset
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic wr_pwr;
  assign wr_pwr = I_REG_WR && (I_REG_ADDR == `DGPC_A_PWR);

  // ============================================================
  // register port and power bits
  AST_RVALID: assert property (I_REG_RD |=> O_REG_RVALID)
    else $error("read valid missing after read strobe");
  AST_RDATA_HOLD: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
    else $error("read data moved without a read");
  AST_PD0: assert property (wr_pwr |-> ##2 O_CH0_PD == $past(I_REG_WDATA[6], 2))
    else $error("channel 0 power down not following bit 6");
  AST_PD1: assert property (wr_pwr |-> ##2 O_CH1_PD == $past(I_REG_WDATA[4], 2))
    else $error("channel 1 power down not following bit 4");
  AST_PD_KEEP: assert property (!wr_pwr |=> ##1 $stable({O_CH0_PD, O_CH1_PD, O_REF_PD, O_BIAS_PD}))
    else $error("power outputs moved without a write");
  AST_REF_BIAS: assert property (wr_pwr |-> ##2
    {O_REF_PD, O_BIAS_PD} == $past({I_REG_WDATA[7], I_REG_WDATA[2]}, 2))
    else $error("reference or bias output wrong");
  AST_SPEED: assert property (I_REG_WR && I_REG_ADDR == `DGPC_A_CAL_CLK |-> ##2
    O_CAL_CLK_SPEED == $past(I_REG_WDATA[5:4], 2))
    else $error("comparator speed not taken");

  // ============================================================
  // output level mapping
  AST_LVL_PD: assert property (O_CH0_PD |=> O_CH0_LEVEL == '0)
    else $error("powered down channel has a level");
  AST_UNS_ZERO: assert property (!O_CH0_PD && !I_TWOS_FMT && !I_NARROW && I_CH0_SAMPLE == '0 |=>
    O_CH0_LEVEL == '0)
    else $error("unsigned zero code gives a level");
  AST_TWOS_MIN: assert property (!O_CH0_PD && I_TWOS_FMT && !I_NARROW && I_CH0_SAMPLE == {1'b1, {(N-1){1'b0}}}
    |=> O_CH0_LEVEL == '0)
    else $error("most negative code not minimum");

  // ============================================================
  // calibration
  AST_COEF_HOLD: assert property (!O_CAL_BUSY && !$past(O_CAL_BUSY) |->
    $stable({O_CH0_CAL_COEF, O_CH1_CAL_COEF}))
    else $error("coefficient moved while idle");
  AST_BUSY_BOUND: assert property ($rose(O_CAL_BUSY) |-> ##[1:100] !O_CAL_BUSY)
    else $error("calibration did not finish");
endmodule // dgpc_top_monitor

bind dgpc_top dgpc_top_monitor #(.N(N)) i_dgpc_top_monitor (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
  .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID), .I_CH0_SAMPLE(I_CH0_SAMPLE),
  .I_TWOS_FMT(I_TWOS_FMT), .I_NARROW(I_NARROW), .O_CH0_LEVEL(O_CH0_LEVEL), .O_CH0_PD(O_CH0_PD),
  .O_CH1_PD(O_CH1_PD), .O_REF_PD(O_REF_PD), .O_BIAS_PD(O_BIAS_PD), .O_CAL_CLK_SPEED(O_CAL_CLK_SPEED),
  .O_CH0_CAL_COEF(O_CH0_CAL_COEF), .O_CH1_CAL_COEF(O_CH1_CAL_COEF), .O_CAL_BUSY(O_CAL_BUSY));
`default_nettype wire

// ### testbench/dgpc_top_tb.sv
// dgpc_top_tb.sv: register level tests of gain, power down and calibration.
// assumes: checker bound from its own file; register strobes one cycle wide.
`timescale 1ns/10ps
`default_nettype none
`include "dgpc_defs.vh"

module dgpc_top_tb;
  localparam N = 16;
  logic I_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic [9:0] I_REG_ADDR = 10'h000;
  logic [7:0] I_REG_WDATA = 8'h00;
  logic I_REG_WR = 1'b0;
  logic I_REG_RD = 1'b0;
  logic [15:0] smp = 16'h0000;
  logic I_TWOS_FMT = 1'b0;
  logic I_NARROW = 1'b0;
  logic I_CH0_CMP = 1'b1;
  logic I_CH1_CMP = 1'b0;
  wire [7:0] O_REG_RDATA;
  wire O_REG_RVALID, O_CH0_PD, O_CH1_PD, O_REF_PD, O_BIAS_PD, O_CAL_BUSY;
  wire [25:0] O_CH0_LEVEL, O_CH1_LEVEL;
  wire [1:0] O_CAL_CLK_SPEED;
  wire [7:0] O_CH0_CAL_COEF, O_CH1_CAL_COEF;
  integer fails = 0;
  integer cmp_count = 0;
  logic [7:0] d;
  logic [7:0] keep;

  dgpc_top #(.N(N)) i_dgpc_top (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
    .O_REG_RVALID(O_REG_RVALID), .I_CH0_SAMPLE(smp), .I_CH1_SAMPLE(smp), .I_TWOS_FMT(I_TWOS_FMT),
    .I_NARROW(I_NARROW), .I_CH0_CMP(I_CH0_CMP), .I_CH1_CMP(I_CH1_CMP), .O_CH0_LEVEL(O_CH0_LEVEL),
    .O_CH1_LEVEL(O_CH1_LEVEL), .O_CH0_PD(O_CH0_PD), .O_CH1_PD(O_CH1_PD), .O_REF_PD(O_REF_PD),
    .O_BIAS_PD(O_BIAS_PD), .O_CAL_CLK_SPEED(O_CAL_CLK_SPEED), .O_CH0_CAL_COEF(O_CH0_CAL_COEF),
    .O_CH1_CAL_COEF(O_CH1_CAL_COEF), .O_CAL_BUSY(O_CAL_BUSY));

  // ============================================================
  // clock and a toggling comparator for channel 1
  always #50 I_CLK = ~I_CLK;
  always @(posedge I_CLK) I_CH1_CMP <= #1 ~I_CH1_CMP;

  // ============================================================
  // compare, verdict and register tasks
  task chk(input logic [25:0] seen, input logic [25:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge I_CLK); #1;
    I_REG_ADDR = a; I_REG_WDATA = v; I_REG_WR = 1'b1;
    @(posedge I_CLK); #1;
    I_REG_WR = 1'b0;
  endtask

  task rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge I_CLK); #1;
    I_REG_ADDR = a; I_REG_RD = 1'b1;
    @(posedge I_CLK); #1;
    I_REG_RD = 1'b0;
    chk(O_REG_RVALID, 1'b1);
    v = O_REG_RDATA;
  endtask

  // expected level: binary code times offset gain
  function automatic logic [25:0] lvl(input logic [15:0] s, input logic tw, input logic nar, input logic [9:0] g);
    logic [15:0] b;
    logic [9:0] m;
    logic [10:0] n;
    n = {s[10] ^ tw, s[9:0]};
    b = nar ? {n, n[10:6]} : (tw ? {~s[15], s[14:0]} : s);
    m = g + `DGPC_GAIN_MID;
    return b * m;
  endfunction

  // one sample setting on both channels, with a different gain on channel 1
  task lvl_case(input logic [9:0] g, input logic [15:0] s, input logic tw, input logic nar);
    logic [9:0] g1;
    g1 = g ^ 10'h155;
    smp = s; I_TWOS_FMT = tw; I_NARROW = nar;
    wr(`DGPC_A_CH0_GU, {6'h00, g[9:8]});
    wr(`DGPC_A_CH0_GL, g[7:0]);
    wr(`DGPC_A_CH1_GU, {6'h00, g1[9:8]});
    wr(`DGPC_A_CH1_GL, g1[7:0]);
    @(posedge I_CLK); #1;
    chk(O_CH0_LEVEL, lvl(s, tw, nar, g));
    chk(O_CH1_LEVEL, lvl(s, tw, nar, g1));
  endtask

  // ============================================================
  // watchdog
  initial begin
    #(5000 * 100);
    fails = fails + 1;
    finish_test;
  end

  // ============================================================
  // test sequence
  initial begin
    repeat (6) @(posedge I_CLK);
    #1 I_RESET = 1'b0;
    rd(`DGPC_A_PWR, d); chk(d, 8'h00);
    rd(`DGPC_A_CH0_GU, d); chk(d, 8'h00);
    rd(`DGPC_A_CH1_GL, d); chk(d, 8'h00);
    rd(`DGPC_A_CAL_CTL, d); chk(d, 8'h00);
    rd(`DGPC_A_CAL_INIT, d); chk(d, 8'h00);
    rd(10'h100, d); chk(d, 8'h00);
    // power down channel 0 only, then both
    smp = 16'hffff;
    wr(`DGPC_A_PWR, 8'h40);
    @(posedge I_CLK); #1;
    chk({O_CH0_PD, O_CH1_PD, O_REF_PD, O_BIAS_PD}, 4'h8);
    @(posedge I_CLK); #1;
    chk(O_CH0_LEVEL, 26'h0);
    chk(O_CH1_LEVEL, lvl(16'hffff, 1'b0, 1'b0, 10'h000));
    wr(`DGPC_A_PWR, 8'h50);
    rd(`DGPC_A_PWR, d); chk(d, 8'h50);
    chk(O_CH1_PD, 1'b1);
    wr(`DGPC_A_PWR, 8'h00);
    // gain and sample mapping
    lvl_case(10'h000, 16'hffff, 1'b0, 1'b0);
    lvl_case(10'h1ff, 16'h8000, 1'b1, 1'b0);
    lvl_case(10'h200, 16'h7fff, 1'b1, 1'b0);
    lvl_case(10'h3ff, 16'h07ff, 1'b0, 1'b1);
    lvl_case(10'h0a5, 16'h03ff, 1'b1, 1'b1);
    wr(`DGPC_A_CH0_GU, 8'hff);
    rd(`DGPC_A_CH0_GU, d); chk(d, 8'h03);
    // calibration of both channels, outputs down meanwhile
    wr(`DGPC_A_PWR, 8'h50);
    wr(`DGPC_A_CAL_CLK, 8'h38);
    wr(`DGPC_A_CAL_SEL, 8'h05);
    chk(O_CAL_CLK_SPEED, 2'h3);
    wr(`DGPC_A_CAL_INIT, 8'ha2);
    wr(`DGPC_A_CAL_CTL, 8'h01);
    wr(`DGPC_A_CAL_CTL, 8'h03);
    @(posedge I_CLK); #1;
    chk(O_CAL_BUSY, 1'b1);
    for (int i = 0; i < 200 && O_CAL_BUSY === 1'b1; i++) begin
      @(posedge I_CLK); #1;
    end
    chk(O_CAL_BUSY, 1'b0);
    wr(`DGPC_A_CAL_CLK, 8'h30);
    wr(`DGPC_A_CAL_SEL, 8'h04);
    rd(`DGPC_A_CAL_CTL, d); chk(d, 8'h83);
    wr(`DGPC_A_CAL_SEL, 8'h01);
    rd(`DGPC_A_CAL_CTL, d); chk(d & 8'h70, 8'h20);
    chk(O_CH0_CAL_COEF, 8'hff);
    keep = O_CH1_CAL_COEF;
    // abort in mid run keeps the old coefficient
    wr(`DGPC_A_CAL_SEL, 8'h04);
    wr(`DGPC_A_CAL_CLK, 8'h38);
    wr(`DGPC_A_CAL_CTL, 8'h03);
    wr(`DGPC_A_CAL_CLK, 8'h30);
    repeat (20) @(posedge I_CLK);
    rd(`DGPC_A_CAL_CTL, d); chk(d & 8'hf0, 8'h10);
    chk(O_CH1_CAL_COEF, keep);
    // reserved select bit flags an error
    wr(`DGPC_A_CAL_CLK, 8'h38);
    wr(`DGPC_A_CAL_SEL, 8'h07);
    wr(`DGPC_A_CAL_CTL, 8'h03);
    repeat (20) @(posedge I_CLK);
    rd(`DGPC_A_CAL_CTL, d); chk(d & 8'h40, 8'h40);
    finish_test;
  end
endmodule // dgpc_top_tb
`default_nettype wire
